// *** core/dsp_decode_pkg.sv ***
// Package of opcode patterns, operation codes and decode result types.
package dsp_decode_pkg;

   // ----------------------------------------------------------------
   // Opcode patterns
   // ----------------------------------------------------------------
   localparam logic [15:0] OPC_STACK_UNLOAD_ACC = 16'hBE32;
   localparam logic [15:0] OPC_STACK_LOAD_ACC   = 16'hBE3C;
   localparam logic [15:0] OPC_RETURN           = 16'hEF00;
   localparam logic [15:0] OPC_PRODUCT_MINUS    = 16'hBE05;
   localparam logic [15:0] OPC_XOR_LONG16       = 16'hBE83;
   localparam logic [7:0]  HI_STACK_TO_MEM      = 8'h8A;
   localparam logic [7:0]  HI_MEM_TO_STACK      = 8'h76;
   localparam logic [5:0]  HI6_COND_RETURN      = 6'b1110_11;
   localparam logic [7:0]  HI_REPEAT_IMM        = 8'hBB;
   localparam logic [7:0]  HI_REPEAT_MEM        = 8'h0B;
   localparam logic [3:0]  NIB_STORE_ACC        = 4'h9;
   localparam logic [7:0]  HI_AUX_DEC           = 8'h7C;
   localparam logic [11:0] HI12_STATUS_SET      = 12'hBE4;
   localparam logic [7:0]  HI_LONG_FORMS        = 8'hBF;
   localparam logic [3:0]  NIB_MINUS_LONG       = 4'hA;
   localparam logic [7:0]  HI_SQUARE_ACC        = 8'h52;
   localparam logic [7:0]  HI_SQUARE_SUB        = 8'h53;
   localparam logic [7:0]  HI_STORE_LONG        = 8'hAE;
   localparam logic [3:0]  NIB_MINUS_SHIFT      = 4'h3;
   localparam logic [7:0]  HI_MINUS_SHORT       = 8'hBA;
   localparam logic [7:0]  HI_MINUS_HIGH        = 8'h65;
   localparam logic [7:0]  HI_MINUS_BORROW      = 8'h64;
   localparam logic [7:0]  HI_COND_MINUS        = 8'h0A;
   localparam logic [7:0]  HI_MINUS_NO_EXT      = 8'h66;
   localparam logic [7:0]  HI_MINUS_T_SHIFT     = 8'h67;
   localparam logic [7:0]  HI_XOR_MEM           = 8'h6C;
   localparam logic [7:0]  HI_ZERO_LOAD_ROUND   = 8'h68;
   localparam logic [7:0]  HI_STATUS_STORE0     = 8'h8E;
   localparam logic [7:0]  HI_STATUS_STORE1     = 8'h8F;

   // ----------------------------------------------------------------
   // Status-bit select codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SEL_CARRY      = 4'hF;
   localparam logic [3:0] SEL_BLOCK_PROG = 4'h5;
   localparam logic [3:0] SEL_INT_DIS    = 4'h1;
   localparam logic [3:0] SEL_OVF_MODE   = 4'h3;
   localparam logic [3:0] SEL_TEST_FLAG  = 4'hB;
   localparam logic [3:0] SEL_EXT_FLAG   = 4'hD;
   localparam logic [3:0] SEL_SIGN_EXT   = 4'h7;

   // ----------------------------------------------------------------
   // Cycle counts
   // ----------------------------------------------------------------
   localparam logic [2:0] CYC_ONE     = 3'h1;
   localparam logic [2:0] CYC_TWO     = 3'h2;
   localparam logic [2:0] CYC_RET     = 3'h4;
   localparam logic [2:0] CYC_RET_NOT = 3'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NONE            = 5'b00000,
      OP_STACK_UNLOAD_ACC= 5'b00001,
      OP_STACK_TO_MEM    = 5'b00010,
      OP_MEM_TO_STACK    = 5'b00011,
      OP_STACK_LOAD_ACC  = 5'b00100,
      OP_RETURN          = 5'b00101,
      OP_COND_RETURN     = 5'b00110,
      OP_REPEAT          = 5'b00111,
      OP_STORE_ACC_HIGH  = 5'b01000,
      OP_STORE_ACC_LOW   = 5'b01001,
      OP_AUX_DEC         = 5'b01010,
      OP_STATUS_SET      = 5'b01011,
      OP_PRODUCT_SHIFT   = 5'b01100,
      OP_SQUARE_ACC      = 5'b01101,
      OP_SQUARE_SUB      = 5'b01110,
      OP_STORE_LONG      = 5'b01111,
      OP_MINUS_SHIFT     = 5'b10000,
      OP_MINUS_LONG      = 5'b10001,
      OP_MINUS_SHORT     = 5'b10010,
      OP_MINUS_HIGH      = 5'b10011,
      OP_MINUS_BORROW    = 5'b10100,
      OP_COND_MINUS      = 5'b10101,
      OP_MINUS_NO_EXT    = 5'b10110,
      OP_MINUS_T_SHIFT   = 5'b10111,
      OP_XOR_MEM         = 5'b11000,
      OP_XOR_LONG        = 5'b11001,
      OP_ZERO_LOAD_ROUND = 5'b11010,
      OP_STATUS_STORE    = 5'b11011,
      OP_PRODUCT_MINUS   = 5'b11100
   } op_t;

   typedef enum logic [0:0] {
      ST_FIRST  = 1'b0,
      ST_SECOND = 1'b1
   } phase_t;

   typedef struct packed {
      op_t         op;
      logic        valid;
      logic        illegal;
      logic        twoWord;
      logic        fromMem;
      logic [7:0]  field;
      logic [3:0]  shift;
      logic [2:0]  select;
      logic [3:0]  statusSel;
      logic [15:0] constant;
      logic [2:0]  cyclesTaken;
      logic [2:0]  cyclesSkipped;
   } decode_t;

endpackage

// *** core/dsp_opcode_decoder.sv ***
// Top of the instruction decoder: word sequencing and registered results.
//
// Function
// - Word BE32 decodes as stack unload into low accumulator, one cycle.
// - Upper byte 8A pops stack to addressed data memory, one cycle.
// - Upper byte 76 pushes addressed data memory onto stack, one cycle.
// - Word BE3C pushes low accumulator onto stack, one cycle.
// - EF00 returns in four; 1110 11TP returns conditionally, four or two.
// - Upper byte BB or 0B repeats next instruction, count immediate or memory.
// - Nibble 9 stores accumulator high or low with three-bit shift.
// - Upper byte 7C subtracts immediate from current auxiliary register.
// - BE4x sets one status bit chosen by the low nibble.
// - Upper byte BF, short form, sets the product output shift mode.
// - Upper bytes 52 and 53 square operand, accumulate or subtract product.
// - Upper byte AE stores following constant word to memory, two cycles.
// - Nibble 3 subtracts operand shifted by bits 11 to 8.
// - BFAx plus constant word subtracts shifted constant, two cycles.
// - Upper byte BA subtracts short immediate from accumulator.
// - Upper bytes 65, 64, 0A, 66, 67 decode the remaining subtract forms.
// - Byte 6C xors operand; BE83 plus constant xors it shifted sixteen.
// - Upper byte 68 zeroes low, loads high with rounding.
// - Upper bytes 8E and 8F store status register zero or one.
// - Word BE05 subtracts product register from accumulator.
`timescale 1ns/1ps
module dsp_opcode_decoder
   import dsp_decode_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rstn,
   input  wire logic [15:0]           fetchWord,
   input  wire logic                  fetchValid,
   output dsp_decode_pkg::decode_t    decoded,
   output logic                       expectConst
);

   import dsp_decode_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      phase_t  phase;
      decode_t pending;
      decode_t out;
   } state_t;

   state_t  cur;
   state_t  next_cur;
   decode_t matched;

   opcode_match u_match
   (
      .word   (fetchWord),
      .result (matched)
   );

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   // A first word of a long form is held until its constant arrives, so
   // the pipeline never sees the constant decoded as an instruction.
   always_comb
   begin
      next_cur       = cur;
      next_cur.out.valid = 1'b0;
      if (fetchValid)
      begin
         case (cur.phase)
            ST_FIRST:
            begin
               if (matched.twoWord)
               begin
                  next_cur.pending = matched;
                  next_cur.phase   = ST_SECOND;
               end
               else
                  next_cur.out = matched;
            end
            ST_SECOND:
            begin
               next_cur.out          = cur.pending;
               next_cur.out.constant = fetchWord;
               next_cur.phase        = ST_FIRST;
            end
            default:
               next_cur.phase = ST_FIRST;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cur <= '0;
      else
         cur <= next_cur;
   end

   assign decoded     = cur.out;
   assign expectConst = cur.phase == ST_SECOND;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_long_first;
      fetchValid && cur.phase == ST_FIRST && matched.twoWord;
   endsequence

   a_const_consumed: assert property (
      @(posedge clock) disable iff (!rstn)
      s_long_first ##1 fetchValid |=> decoded.valid &&
         decoded.twoWord && decoded.constant == $past(fetchWord))
      else $error("constant word not attached to long form");

   a_long_waits: assert property (
      @(posedge clock) disable iff (!rstn)
      s_long_first |=> !decoded.valid && expectConst)
      else $error("long form issued before its constant");

   a_unload_acc: assert property (
      @(posedge clock) disable iff (!rstn)
      fetchValid && !expectConst && fetchWord == OPC_STACK_UNLOAD_ACC
      |=> decoded.op == OP_STACK_UNLOAD_ACC &&
          decoded.cyclesTaken == CYC_ONE)
      else $error("stack unload word misdecoded");

   a_return_cycles: assert property (
      @(posedge clock) disable iff (!rstn)
      fetchValid && !expectConst && fetchWord[15:10] == HI6_COND_RETURN
      |=> decoded.cyclesTaken == CYC_RET &&
          (decoded.op == OP_RETURN ||
           decoded.cyclesSkipped == CYC_RET_NOT))
      else $error("return cycle counts wrong");

   a_status_set: assert property (
      @(posedge clock) disable iff (!rstn)
      fetchValid && !expectConst && fetchWord == {HI12_STATUS_SET,
         SEL_EXT_FLAG}
      |=> decoded.op == OP_STATUS_SET && !decoded.illegal &&
          decoded.statusSel == SEL_EXT_FLAG)
      else $error("status set decode wrong");

   a_store_shift: assert property (
      @(posedge clock) disable iff (!rstn)
      fetchValid && !expectConst && fetchWord[15:12] == NIB_STORE_ACC
      |=> decoded.select == $past(fetchWord[10:8]) &&
          (decoded.op == OP_STORE_ACC_HIGH) == $past(fetchWord[11]))
      else $error("accumulator store decode wrong");

   a_minus_shift: assert property (
      @(posedge clock) disable iff (!rstn)
      fetchValid && !expectConst && fetchWord[15:12] == NIB_MINUS_SHIFT
      |=> decoded.op == OP_MINUS_SHIFT &&
          decoded.shift == $past(fetchWord[11:8]))
      else $error("shifted subtract decode wrong");

   a_status_store: assert property (
      @(posedge clock) disable iff (!rstn)
      fetchValid && !expectConst && fetchWord[15:8] == HI_STATUS_STORE1
      |=> decoded.op == OP_STATUS_STORE && decoded.select == 3'h1)
      else $error("status store decode wrong");

   a_idle_quiet: assert property (
      @(posedge clock) disable iff (!rstn)
      !fetchValid |=> !decoded.valid)
      else $error("result issued without a fetched word");

endmodule

// *** core/field_split.sv ***
// Splits an instruction word into its upper byte, nibbles and low byte.
`timescale 1ns/1ps
module field_split
   import dsp_decode_pkg::*;
(
   input  wire logic [15:0] word,
   output logic      [7:0]  upper,
   output logic      [7:0]  lower,
   output logic      [3:0]  nib3,
   output logic      [3:0]  nib2
);

   // ----------------------------------------------------------------
   // Field slices, taken from the most significant nibble down.
   // ----------------------------------------------------------------
   assign upper = word[15:8];
   assign lower = word[7:0];
   assign nib3  = word[15:12];
   assign nib2  = word[11:8];

endmodule

// *** core/opcode_match.sv ***
// Combinational classifier of one first instruction word.
`timescale 1ns/1ps
module opcode_match
   import dsp_decode_pkg::*;
(
   input  wire logic [15:0] word,
   output decode_t          result
);

   logic [7:0] upper;
   logic [7:0] lower;
   logic [3:0] nib3;
   logic [3:0] nib2;

   field_split u_split
   (
      .word  (word),
      .upper (upper),
      .lower (lower),
      .nib3  (nib3),
      .nib2  (nib2)
   );

   // ----------------------------------------------------------------
   // Pattern match; exact words are tried before byte and nibble forms.
   // ----------------------------------------------------------------
   always_comb
   begin
      result               = '0;
      result.op            = OP_NONE;
      result.valid         = 1'b1;
      result.field         = lower;
      result.cyclesTaken   = CYC_ONE;
      result.cyclesSkipped = CYC_ONE;
      if (word == OPC_STACK_UNLOAD_ACC)
         result.op = OP_STACK_UNLOAD_ACC;
      else if (word == OPC_STACK_LOAD_ACC)
         result.op = OP_STACK_LOAD_ACC;
      else if (word == OPC_PRODUCT_MINUS)
         result.op = OP_PRODUCT_MINUS;
      else if (word == OPC_XOR_LONG16)
      begin
         result.op          = OP_XOR_LONG;
         result.twoWord     = 1'b1;
         result.shift       = 4'hF;                   // Flagged as 16.
         result.cyclesTaken = CYC_TWO;
      end
      else if (word == OPC_RETURN)
      begin
         result.op            = OP_RETURN;
         result.cyclesTaken   = CYC_RET;
         result.cyclesSkipped = CYC_RET;
      end
      else if (word[15:10] == HI6_COND_RETURN)
      begin
         result.op            = OP_COND_RETURN;
         result.select        = {1'b0, word[9:8]};
         result.cyclesTaken   = CYC_RET;
         result.cyclesSkipped = CYC_RET_NOT;
      end
      else if (word[15:4] == HI12_STATUS_SET)
      begin
         result.op        = OP_STATUS_SET;
         result.statusSel = word[3:0];
         case (word[3:0])
            SEL_CARRY, SEL_BLOCK_PROG, SEL_INT_DIS, SEL_OVF_MODE,
            SEL_TEST_FLAG, SEL_EXT_FLAG, SEL_SIGN_EXT:
               result.illegal = 1'b0;
            default:
               result.illegal = 1'b1;
         endcase
      end
      else if (upper == HI_LONG_FORMS && word[7:4] == NIB_MINUS_LONG)
      begin
         result.op          = OP_MINUS_LONG;
         result.twoWord     = 1'b1;
         result.shift       = word[3:0];
         result.cyclesTaken = CYC_TWO;
      end
      // BF0 with bit 3 set is the long aux-register load; it stays illegal
      // here so that the word itself is never taken as shift mode.
      else if (upper == HI_LONG_FORMS && !word[7] &&
               !(word[7:4] == 4'h0 && word[3]))
         result.op = OP_PRODUCT_SHIFT;
      else if (nib3 == NIB_STORE_ACC)
      begin
         result.op     = nib2[3] ? OP_STORE_ACC_HIGH
                                 : OP_STORE_ACC_LOW;
         result.select = nib2[2:0];
      end
      else if (nib3 == NIB_MINUS_SHIFT)
      begin
         result.op    = OP_MINUS_SHIFT;
         result.shift = nib2;
      end
      else
      begin
         case (upper)
            HI_STACK_TO_MEM:  result.op = OP_STACK_TO_MEM;
            HI_MEM_TO_STACK:  result.op = OP_MEM_TO_STACK;
            HI_REPEAT_IMM:    result.op = OP_REPEAT;
            HI_REPEAT_MEM:
            begin
               result.op      = OP_REPEAT;
               result.fromMem = 1'b1;
            end
            HI_AUX_DEC:       result.op = OP_AUX_DEC;
            HI_SQUARE_ACC:    result.op = OP_SQUARE_ACC;
            HI_SQUARE_SUB:    result.op = OP_SQUARE_SUB;
            HI_STORE_LONG:
            begin
               result.op          = OP_STORE_LONG;
               result.twoWord     = 1'b1;
               result.cyclesTaken = CYC_TWO;
            end
            HI_MINUS_SHORT:   result.op = OP_MINUS_SHORT;
            HI_MINUS_HIGH:    result.op = OP_MINUS_HIGH;
            HI_MINUS_BORROW:  result.op = OP_MINUS_BORROW;
            HI_COND_MINUS:    result.op = OP_COND_MINUS;
            HI_MINUS_NO_EXT:  result.op = OP_MINUS_NO_EXT;
            HI_MINUS_T_SHIFT: result.op = OP_MINUS_T_SHIFT;
            HI_XOR_MEM:       result.op = OP_XOR_MEM;
            HI_ZERO_LOAD_ROUND: result.op = OP_ZERO_LOAD_ROUND;
            HI_STATUS_STORE0, HI_STATUS_STORE1:
            begin
               result.op     = OP_STATUS_STORE;
               result.select = {2'b00, upper[0]};
            end
            default:
            begin
               result.op      = OP_NONE;
               result.illegal = 1'b1;
            end
         endcase
      end
   end

endmodule

// *** tb/dsp_opcode_decoder_test.sv ***
// Self-checking testbench for the instruction decoder.
`timescale 1ns/1ps
`define CHECK(got, exp, what) \
   checks++; \
   if ((got) !== (exp)) \
   begin \
      fails++; \
      $display("unexpected at %0t: %s", $time, what); \
   end
module dsp_opcode_decoder_test;
   import dsp_decode_pkg::*;

   logic        clock = 1'b0;
   logic        rstn;
   logic [15:0] fetchWord;
   logic        fetchValid;
   decode_t     decoded;
   logic        expectConst;
   int          fails;
   int          checks;

   // ------------------------------------------------------------
   // Clock, partner and design
   // ------------------------------------------------------------
   // Half period of 4 ns gives the 125 MHz core clock.
   always #4 clock = ~clock;

   fetch_model i_fetch_model
   (
      .clock      (clock),
      .fetchWord  (fetchWord),
      .fetchValid (fetchValid)
   );

   dsp_opcode_decoder i_dsp_opcode_decoder
   (
      .clock       (clock),
      .rstn        (rstn),
      .fetchWord   (fetchWord),
      .fetchValid  (fetchValid),
      .decoded     (decoded),
      .expectConst (expectConst)
   );

   // ------------------------------------------------------------
   // Shared checks
   // ------------------------------------------------------------
   // Word count follows the cycle count: only two-word forms take two.
   task automatic expect_op(input op_t op, input logic [2:0] cyc,
                            input logic [7:0] fld, input bit useFld);
      `CHECK(decoded.valid, 1'b1, "no result pulse")
      `CHECK(decoded.op, op, "wrong operation")
      `CHECK(decoded.illegal, 1'b0, "flagged illegal")
      `CHECK(decoded.cyclesTaken, cyc, "wrong cycle count")
      `CHECK(decoded.twoWord, cyc == CYC_TWO, "wrong word count")
      if (useFld)
      begin
         `CHECK(decoded.field, fld, "wrong low field")
      end
   endtask

   // One word, one idle cycle, then the registered result is judged.
   task automatic do_one(input logic [15:0] w, input op_t op,
                         input logic [2:0] cyc, input bit useFld);
      i_fetch_model.drive(w);
      i_fetch_model.idle();
      expect_op(op, cyc, w[7:0], useFld);
   endtask

   // A gap is left before the constant to show pairing survives it.
   task automatic do_long(input logic [15:0] w1, input logic [15:0] w2,
                          input op_t op);
      i_fetch_model.drive(w1);
      i_fetch_model.idle();
      `CHECK(decoded.valid, 1'b0, "early result")
      `CHECK(expectConst, 1'b1, "constant not awaited")
      i_fetch_model.idle();
      i_fetch_model.drive(w2);
      i_fetch_model.idle();
      expect_op(op, CYC_TWO, 8'h00, 0);
      `CHECK(decoded.constant, w2, "constant word")
      `CHECK(expectConst, 1'b0, "constant still awaited")
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Stack forms sent back to back, each result seen as the next word
   // is presented.
   task automatic test_stack();
      i_fetch_model.drive(16'hBE32);
      i_fetch_model.drive(16'h8A55);
      expect_op(OP_STACK_UNLOAD_ACC, CYC_ONE, 8'h00, 0);
      i_fetch_model.drive(16'h76AA);
      expect_op(OP_STACK_TO_MEM, CYC_ONE, 8'h55, 1);
      i_fetch_model.drive(16'hBE3C);
      expect_op(OP_MEM_TO_STACK, CYC_ONE, 8'hAA, 1);
      i_fetch_model.idle();
      expect_op(OP_STACK_LOAD_ACC, CYC_ONE, 8'h00, 0);
      $display("test_stack done");
   endtask

   task automatic test_flow();
      do_one(16'hEF00, OP_RETURN, CYC_RET, 1);
      do_one(16'hEE5A, OP_COND_RETURN, CYC_RET, 1);
      `CHECK(decoded.cyclesSkipped, CYC_RET_NOT, "skip cycles")
      `CHECK(decoded.select, 3'h2, "condition bits")
      do_one(16'hBB07, OP_REPEAT, CYC_ONE, 1);
      `CHECK(decoded.fromMem, 1'b0, "repeat source")
      do_one(16'h0B33, OP_REPEAT, CYC_ONE, 1);
      `CHECK(decoded.fromMem, 1'b1, "repeat source")
      do_one(16'h9D44, OP_STORE_ACC_HIGH, CYC_ONE, 1);
      `CHECK(decoded.select, 3'h5, "store shift")
      do_one(16'h9344, OP_STORE_ACC_LOW, CYC_ONE, 1);
      `CHECK(decoded.select, 3'h3, "store shift")
      do_one(16'h7CFF, OP_AUX_DEC, CYC_ONE, 1);
      $display("test_flow done");
   endtask

   // Every status select code, then an unlisted one that must be refused.
   task automatic test_status();
      logic [3:0] sels [7] = '{4'hF, 4'h5, 4'h1, 4'h3, 4'hB, 4'hD, 4'h7};
      for (int i = 0; i < 7; i++)
      begin
         do_one({12'hBE4, sels[i]}, OP_STATUS_SET, CYC_ONE, 1);
         `CHECK(decoded.statusSel, sels[i], "status bit")
      end
      i_fetch_model.drive(16'hBE40);
      i_fetch_model.idle();
      `CHECK(decoded.valid, 1'b1, "no result pulse")
      `CHECK(decoded.illegal, 1'b1, "unlisted code accepted")
      `CHECK(decoded.op, OP_STATUS_SET, "unlisted code misrouted")
      $display("test_status done");
   endtask

   task automatic test_arith();
      do_one(16'hBF04, OP_PRODUCT_SHIFT, CYC_ONE, 1);
      i_fetch_model.drive(16'hBF08);
      i_fetch_model.idle();
      `CHECK(decoded.illegal, 1'b1, "long form as shift mode")
      do_one(16'h5210, OP_SQUARE_ACC, CYC_ONE, 1);
      do_one(16'h5311, OP_SQUARE_SUB, CYC_ONE, 1);
      do_one(16'h3A20, OP_MINUS_SHIFT, CYC_ONE, 1);
      `CHECK(decoded.shift, 4'hA, "operand shift")
      do_one(16'hBA40, OP_MINUS_SHORT, CYC_ONE, 1);
      do_one(16'h6501, OP_MINUS_HIGH, CYC_ONE, 1);
      do_one(16'h6402, OP_MINUS_BORROW, CYC_ONE, 1);
      do_one(16'h0A03, OP_COND_MINUS, CYC_ONE, 1);
      do_one(16'h6604, OP_MINUS_NO_EXT, CYC_ONE, 1);
      do_one(16'h6705, OP_MINUS_T_SHIFT, CYC_ONE, 1);
      do_one(16'h6C06, OP_XOR_MEM, CYC_ONE, 1);
      do_one(16'h6807, OP_ZERO_LOAD_ROUND, CYC_ONE, 1);
      do_one(16'h8E08, OP_STATUS_STORE, CYC_ONE, 1);
      `CHECK(decoded.select, 3'h0, "status register")
      do_one(16'h8F09, OP_STATUS_STORE, CYC_ONE, 1);
      `CHECK(decoded.select, 3'h1, "status register")
      do_one(16'hBE05, OP_PRODUCT_MINUS, CYC_ONE, 1);
      $display("test_arith done");
   endtask

   // The first constant looks like an opcode, so it must not decode.
   task automatic test_long();
      do_long(16'hAE10, 16'hBE32, OP_STORE_LONG);
      `CHECK(decoded.field, 8'h10, "store address")
      do_long(16'hBFA5, 16'h8001, OP_MINUS_LONG);
      `CHECK(decoded.shift, 4'h5, "constant shift")
      do_long(16'hBE83, 16'h0F0F, OP_XOR_LONG);
      `CHECK(decoded.shift, 4'hF, "shift of sixteen")
      do_one(16'hBE32, OP_STACK_UNLOAD_ACC, CYC_ONE, 0);
      $display("test_long done");
   endtask

   // Reset between the two words of a pair drops the pending constant.
   task automatic test_reset();
      i_fetch_model.drive(16'hAE10);
      i_fetch_model.idle();
      `CHECK(expectConst, 1'b1, "constant not awaited")
      rstn <= 1'b0;
      @(negedge clock);
      `CHECK(expectConst, 1'b0, "pair kept over reset")
      `CHECK(decoded.valid, 1'b0, "result during reset")
      rstn <= 1'b1;
      do_one(16'hBE32, OP_STACK_UNLOAD_ACC, CYC_ONE, 0);
      $display("test_reset done");
   endtask

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      rstn   = 1'b0;
      fails  = 0;
      checks = 0;
      repeat (2) @(negedge clock);
      rstn <= 1'b1;
      test_stack();
      test_flow();
      test_status();
      test_arith();
      test_long();
      test_reset();
      test_done();
   end

   // The whole run needs about ninety cycles; this leaves wide margin.
   initial
   begin
      repeat (3000) @(posedge clock);
      fails++;
      $display("unexpected at %0t: run did not finish", $time);
      test_done();
   end
endmodule

// *** tb/fetch_model.sv ***
// Fetch-stage model that hands instruction words to the decoder.
`timescale 1ns/1ps
module fetch_model
(
   input  wire logic        clock,
   output logic      [15:0] fetchWord,
   output logic             fetchValid
);
   // ------------------------------------------------------------
   // Word delivery
   // ------------------------------------------------------------
   // Quiet bus at time zero so the decoder never sees an unknown strobe.
   initial
   begin
      fetchWord  = 16'h0000;
      fetchValid = 1'b0;
   end

   // Presents one word and holds it until the next call; chaining calls gives
   // back-to-back delivery with no idle cycle between words.
   task automatic drive(input logic [15:0] word);
      @(negedge clock);
      fetchWord  <= word;
      fetchValid <= 1'b1;
   endtask

   // Idle cycle: the word is not qualified, so it is scrambled to stop
   // a decoder from leaning on a stale value.
   task automatic idle();
      @(negedge clock);
      fetchValid <= 1'b0;
      fetchWord  <= ~fetchWord;
   endtask
endmodule
